/* shared/aips_regs.vh */
// Constants for the node identifier power-on selection block
// What this block does
// [RQ1] At power-on copy the setup table into working RAM; run from that copy.
// [RQ2] Accept software-assigned identifiers 1 to 255 and store them in the table.
// [RQ3] CANopen mode: identifier above 127 becomes 255, block goes unconfigured.
// [RQ4] Unconfigured: accept only layer setting service commands, drop all others.
// [RQ5] Unconfigured: send only layer setting service replies, no boot-up message.
// [RQ6] Serial-link write of identifier 1 to 127 leaves the unconfigured state.
// [RQ7] Valid table with selection flag: use table identifier or switch code.
// [RQ8] Valid table, flag clear: use last identifier set by table or master.
// [RQ9] Invalid table, identifier retained: use the retained identifier.
// [RQ10] Invalid table, nothing retained: use the hexadecimal rotary switch.
// [RQ11] Sample switch and select only once per power-on; hold until reassigned.
`ifndef AIPS_REGS_VH
`define AIPS_REGS_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define AIPS_CTRL 8'h00
`define AIPS_STAT 8'h04
`define AIPS_ASGN 8'h08
`define AIPS_RETN 8'h0C
`define AIPS_RAM_SEL 3'h1
`define AIPS_CTRL_RST 1'b1

// -----------------------------------------------------------------
// Setup table layout
// -----------------------------------------------------------------
`define AIPS_TBL_LAST 4'h7
`define AIPS_RET_IDX 4'h8
`define AIPS_TBL_IDX 4'h0
`define AIPS_SIG 16'hA5C3
`define AIPS_SIG_MSB 31
`define AIPS_SIG_LSB 16
`define AIPS_SEL_BIT 8
`define AIPS_RSET_BIT 8
`define AIPS_ID_MSB 7

// -----------------------------------------------------------------
// Identifier values and selection sources
// -----------------------------------------------------------------
`define AIPS_ID_SWITCH 8'h00
`define AIPS_ID_CO_MAX 8'h7F
`define AIPS_ID_UNCONF 8'hFF
`define AIPS_SRC_TABLE 2'h0
`define AIPS_SRC_RETAIN 2'h1
`define AIPS_SRC_SWITCH 2'h2
`define AIPS_SRC_ASSIGN 2'h3

// -----------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------
`define AIPS_OKAY 2'h0
`define AIPS_SLVERR 2'h2

`endif

/* hdl/aips_nv_loader.v */
// Nonvolatile store sequencer: power-on read-out and later word writes
`timescale 1ns/1ps
`default_nettype none
`include "aips_regs.vh"
module aips_nv_loader (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Nonvolatile store port
  output wire nv_req_o,
  output wire nv_we_o,
  output wire [3:0] nv_addr_o,
  output wire [31:0] nv_wdata_o,
  input wire [31:0] nv_rdata_i,
  input wire nv_ack_i,
  // Load stream
  output wire ld_we_o,
  output wire [3:0] ld_idx_o,
  output wire [31:0] ld_data_o,
  output wire ld_done_o,
  // Write request
  input wire wr_req_i,
  input wire [3:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  output wire wr_ack_o
);
  localparam L_RD = 2'h0;
  localparam L_IDLE = 2'h1;
  localparam L_WR = 2'h2;
  reg [1:0] st_q;
  reg [3:0] addr_q;
  reg [31:0] wdata_q;
  reg ld_we_q;
  reg [3:0] ld_idx_q;
  reg [31:0] ld_data_q;

  assign nv_req_o = (st_q == L_RD) || (st_q == L_WR);
  assign nv_we_o = (st_q == L_WR);
  assign nv_addr_o = addr_q;
  assign nv_wdata_o = wdata_q;
  assign ld_we_o = ld_we_q;
  assign ld_idx_o = ld_idx_q;
  assign ld_data_o = ld_data_q;
  assign ld_done_o = (st_q != L_RD) && !ld_we_q;
  assign wr_ack_o = (st_q == L_WR) && nv_ack_i;

  // Reads every table word and the retained word once, then serves writes
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= L_RD;
      addr_q <= `AIPS_TBL_IDX;
      wdata_q <= 32'h0000_0000;
      ld_we_q <= 1'b0;
      ld_idx_q <= 4'h0;
      ld_data_q <= 32'h0000_0000;
    end else begin
      ld_we_q <= 1'b0;
      case (st_q)
        L_RD: begin
          if (nv_ack_i) begin
            ld_we_q <= 1'b1; // [RQ1]
            ld_idx_q <= addr_q;
            ld_data_q <= nv_rdata_i;
            if (addr_q == `AIPS_RET_IDX) begin
              st_q <= L_IDLE;
            end else begin
              addr_q <= addr_q + 4'h1;
            end
          end
        end
        L_IDLE: begin
          if (wr_req_i) begin
            st_q <= L_WR;
            addr_q <= wr_addr_i;
            wdata_q <= wr_data_i;
          end
        end
        L_WR: begin
          if (nv_ack_i) begin
            st_q <= L_IDLE;
          end
        end
        default: begin
          st_q <= L_IDLE;
        end
      endcase
    end
  end
endmodule // aips_nv_loader
`default_nettype wire

/* hdl/aips_top.v */
// Node identifier power-on selection with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "aips_regs.vh"
module aips_top (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // AXI4-Lite write address and data
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Nonvolatile store
  output wire nv_req_o,
  output wire nv_we_o,
  output wire [3:0] nv_addr_o,
  output wire [31:0] nv_wdata_o,
  input wire [31:0] nv_rdata_i,
  input wire nv_ack_i,
  // Rotary switch pins
  input wire [3:0] node_id_rotary_switch_i,
  // Identifier assignment from the layer setting service engine
  input wire lss_id_valid_i,
  input wire [7:0] lss_id_i,
  // Received command filter
  input wire rx_cmd_valid_i,
  input wire rx_cmd_is_lss_i,
  output wire rx_accept_o,
  // Transmit gate
  input wire tx_req_i,
  input wire tx_is_lss_i,
  output wire tx_allow_o,
  // Identifier state
  output wire [7:0] node_identifier_o,
  output wire unconfigured_o,
  output wire id_ready_o,
  output wire boot_up_o,
  // Runtime setup read port
  input wire [2:0] setup_idx_i,
  output wire [31:0] setup_data_o
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  localparam S_LOAD = 2'h0;
  localparam S_EVAL = 2'h1;
  localparam S_RUN = 2'h2;
  reg [1:0] st_q;
  reg [31:0] ram_q [0:7];
  reg [31:0] ret_q;
  reg [7:0] id_q;
  reg unconf_q;
  reg [1:0] src_q;
  reg boot_q;
  reg co_mode_q;
  reg [7:0] asgn_q;
  reg pend_tbl_q;
  reg pend_ret_q;
  reg [3:0] sw_meta_q;
  reg [3:0] sw_q;
  reg [31:0] setup_q;
  wire ld_we;
  wire [3:0] ld_idx;
  wire [31:0] ld_data;
  wire ld_done;
  wire wr_ack;
  wire wr_ret;

  // -----------------------------------------------------------------
  // Store sequencer
  // -----------------------------------------------------------------
  // Table word written first so a power loss leaves the retained copy old
  assign wr_ret = !pend_tbl_q;
  aips_nv_loader u_nv (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .nv_req_o(nv_req_o),
    .nv_we_o(nv_we_o),
    .nv_addr_o(nv_addr_o),
    .nv_wdata_o(nv_wdata_o),
    .nv_rdata_i(nv_rdata_i),
    .nv_ack_i(nv_ack_i),
    .ld_we_o(ld_we),
    .ld_idx_o(ld_idx),
    .ld_data_o(ld_data),
    .ld_done_o(ld_done),
    .wr_req_i(pend_tbl_q || pend_ret_q),
    .wr_addr_i(wr_ret ? `AIPS_RET_IDX : `AIPS_TBL_IDX),
    .wr_data_i(wr_ret ? ret_q : ram_q[0]),
    .wr_ack_o(wr_ack)
  );

  // Switch pins come from outside: two flops before any use
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_meta_q <= 4'h0;
      sw_q <= 4'h0;
    end else begin
      sw_meta_q <= node_id_rotary_switch_i;
      sw_q <= sw_meta_q;
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite slave
  // -----------------------------------------------------------------
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire wr_fire;
  wire wr_asgn;
  wire wr_ctrl;
  wire wr_ok;
  wire [7:0] w_id;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign w_id = wdata_q[`AIPS_ID_MSB:0];
  assign wr_ctrl = wr_fire && (awaddr_q == `AIPS_CTRL);
  // Identifier zero is the switch code and cannot be assigned by hand
  assign wr_asgn = wr_fire && (awaddr_q == `AIPS_ASGN) && wstrb_q[0] &&
                   (st_q == S_RUN) && (w_id != `AIPS_ID_SWITCH);
  assign wr_ok = wr_ctrl || wr_asgn;

  // Address and data are latched in either order, then answered
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `AIPS_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `AIPS_OKAY : `AIPS_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read mux: status, control, assignment, retained word and the RAM copy
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `AIPS_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `AIPS_OKAY;
      rdata_q <= 32'h0000_0000;
      if (s_axi_araddr[7:5] == `AIPS_RAM_SEL && s_axi_araddr[1:0] == 2'h0) begin
        rdata_q <= ram_q[s_axi_araddr[4:2]];
      end else begin
        case (s_axi_araddr)
          `AIPS_CTRL: rdata_q <= {31'h0000_0000, co_mode_q};
          `AIPS_STAT: rdata_q <= {20'h00000, src_q, (st_q == S_RUN),
                                  unconf_q, id_q};
          `AIPS_ASGN: rdata_q <= {24'h000000, asgn_q};
          `AIPS_RETN: rdata_q <= ret_q;
          default: rresp_q <= `AIPS_SLVERR;
        endcase
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // CANopen mode bit steers the identifier conversion
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      co_mode_q <= `AIPS_CTRL_RST;
    end else if (wr_ctrl && wstrb_q[0]) begin
      co_mode_q <= wdata_q[0];
    end
  end

  // -----------------------------------------------------------------
  // Working RAM copy of the setup table
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ram
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ram_q[gi] <= 32'h0000_0000;
        end else if (ld_we && ld_idx == gi) begin
          ram_q[gi] <= ld_data; // [RQ1]
        end else if (gi == 0 && wr_asgn) begin
          // Software identifier kept in the table, selection flag set
          ram_q[gi] <= {`AIPS_SIG, 7'h00, 1'b1, w_id}; // [RQ2]
        end
      end
    end
  endgenerate

  // Runtime reads go to the RAM copy, never the slow store
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup_q <= 32'h0000_0000;
    end else begin
      setup_q <= ram_q[setup_idx_i]; // [RQ1]
    end
  end
  assign setup_data_o = setup_q;

  // -----------------------------------------------------------------
  // Power-on selection
  // -----------------------------------------------------------------
  reg [7:0] raw_id;
  reg [1:0] raw_src;
  reg [7:0] fin_id;
  reg fin_unconf;
  reg [7:0] lss_fin;
  wire tbl_valid;
  wire tbl_sel;
  wire ret_set;
  wire [7:0] sw_id;

  assign tbl_valid = ram_q[0][`AIPS_SIG_MSB:`AIPS_SIG_LSB] == `AIPS_SIG;
  assign tbl_sel = ram_q[0][`AIPS_SEL_BIT];
  assign ret_set = ret_q[`AIPS_RSET_BIT];
  assign sw_id = {4'h0, sw_q};

  // Choose the source in the documented order of precedence
  always @* begin
    raw_id = sw_id;
    raw_src = `AIPS_SRC_SWITCH;
    if (tbl_valid && tbl_sel) begin
      raw_id = ram_q[0][`AIPS_ID_MSB:0]; // [RQ7]
      raw_src = `AIPS_SRC_TABLE;
    end else if (ret_set) begin
      raw_id = ret_q[`AIPS_ID_MSB:0]; // [RQ8] [RQ9]
      raw_src = `AIPS_SRC_RETAIN;
    end
    // Switch code, or nothing retained, falls back to the switch
    if (raw_id == `AIPS_ID_SWITCH) begin
      raw_id = sw_id; // [RQ10]
      raw_src = `AIPS_SRC_SWITCH;
    end
    // Switch at zero gives no usable node: identifier 255, unconfigured only in CANopen mode
    fin_id = raw_id;
    fin_unconf = 1'b0;
    if (raw_id == `AIPS_ID_SWITCH) begin
      fin_id = `AIPS_ID_UNCONF;
      fin_unconf = co_mode_q;
    end else if (co_mode_q && raw_id > `AIPS_ID_CO_MAX) begin
      fin_id = `AIPS_ID_UNCONF; // [RQ3]
      fin_unconf = 1'b1;
    end
    lss_fin = lss_id_i;
    if (co_mode_q && lss_id_i > `AIPS_ID_CO_MAX) begin
      lss_fin = `AIPS_ID_UNCONF;
    end
  end

  // One evaluation per power-on; later changes only by explicit assignment
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_LOAD;
      id_q <= `AIPS_ID_UNCONF;
      unconf_q <= 1'b1;
      src_q <= `AIPS_SRC_SWITCH;
      boot_q <= 1'b0;
      asgn_q <= 8'h00;
      ret_q <= 32'h0000_0000;
      pend_tbl_q <= 1'b0;
      pend_ret_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (ld_we && ld_idx == `AIPS_RET_IDX) begin
        ret_q <= ld_data;
      end
      if (wr_ack && !wr_ret) begin
        pend_tbl_q <= 1'b0;
      end
      if (wr_ack && wr_ret) begin
        pend_ret_q <= 1'b0;
      end
      case (st_q)
        S_LOAD: begin
          if (ld_done) begin
            st_q <= S_EVAL;
          end
        end
        S_EVAL: begin
          st_q <= S_RUN;
          id_q <= fin_id; // [RQ11]
          unconf_q <= fin_unconf;
          src_q <= raw_src;
          boot_q <= co_mode_q && !fin_unconf; // [RQ5]
          // A table value in force becomes the last value set
          if (raw_src == `AIPS_SRC_TABLE) begin
            ret_q <= {23'h000000, 1'b1, raw_id};
            pend_ret_q <= 1'b1;
          end
        end
        S_RUN: begin
          if (wr_asgn) begin
            asgn_q <= w_id;
            src_q <= `AIPS_SRC_ASSIGN;
            ret_q <= {23'h000000, 1'b1, w_id}; // [RQ2]
            pend_tbl_q <= 1'b1;
            pend_ret_q <= 1'b1;
            if (co_mode_q && w_id > `AIPS_ID_CO_MAX) begin
              id_q <= `AIPS_ID_UNCONF; // [RQ3]
              unconf_q <= 1'b1;
            end else begin
              id_q <= w_id; // [RQ6]
              unconf_q <= 1'b0;
              boot_q <= co_mode_q && unconf_q; // [RQ6]
            end
          end else if (lss_id_valid_i && lss_id_i != `AIPS_ID_SWITCH) begin
            // Master assignment is retained for the next power-on
            id_q <= lss_fin;
            unconf_q <= co_mode_q && (lss_fin == `AIPS_ID_UNCONF);
            src_q <= `AIPS_SRC_ASSIGN;
            ret_q <= {23'h000000, 1'b1, lss_fin};
            pend_ret_q <= 1'b1;
            boot_q <= co_mode_q && unconf_q &&
                      (lss_fin != `AIPS_ID_UNCONF); // [RQ5]
          end
        end
        default: begin
          st_q <= S_LOAD;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Traffic gates
  // -----------------------------------------------------------------
  // Until selection ends the node counts as unconfigured
  assign rx_accept_o = rx_cmd_valid_i &&
                       (rx_cmd_is_lss_i || !unconf_q); // [RQ4]
  assign tx_allow_o = tx_req_i && (tx_is_lss_i || !unconf_q); // [RQ5]
  assign node_identifier_o = id_q;
  assign unconfigured_o = unconf_q;
  assign id_ready_o = (st_q == S_RUN);
  assign boot_up_o = boot_q;
endmodule // aips_top
`default_nettype wire

/* verif/aips_top_properties.sv */
// Concurrent checks on the identifier selection block ports
`timescale 1ns/1ps
`default_nettype none
module aips_top_properties (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Bus and assignment activity
  input wire logic s_axi_bvalid,
  input wire logic lss_id_valid_i,
  // Store port
  input wire logic nv_req_o,
  input wire logic nv_we_o,
  input wire logic [3:0] nv_addr_o,
  input wire logic nv_ack_i,
  // Command and transmit filters
  input wire logic rx_cmd_valid_i,
  input wire logic rx_cmd_is_lss_i,
  input wire logic rx_accept_o,
  input wire logic tx_req_i,
  input wire logic tx_is_lss_i,
  input wire logic tx_allow_o,
  // Identifier state
  input wire logic [7:0] node_identifier_o,
  input wire logic unconfigured_o,
  input wire logic id_ready_o,
  input wire logic boot_up_o
);
  default clocking dcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_rx_filter: assert property (rx_accept_o ==
    (rx_cmd_valid_i && (rx_cmd_is_lss_i || !unconfigured_o)))
    else $error("received command filter wrong");
  a_tx_gate: assert property (tx_allow_o ==
    (tx_req_i && (tx_is_lss_i || !unconfigured_o)))
    else $error("transmit gate wrong");
  a_unconf_id: assert property (unconfigured_o |->
    node_identifier_o == 8'hFF)
    else $error("unconfigured node without identifier 255");
  a_boot_cfg: assert property (boot_up_o |-> !unconfigured_o &&
    node_identifier_o != 8'h00 && node_identifier_o <= 8'h7F)
    else $error("boot-up message while not configured");
  a_boot_pulse: assert property (boot_up_o |=> !boot_up_o)
    else $error("boot-up pulse longer than one cycle");
  a_ready_hold: assert property (id_ready_o |=> id_ready_o)
    else $error("selection done flag dropped");
  // Identifier moves only on a register write or an LSS assignment
  a_id_stable: assert property (id_ready_o && $past(id_ready_o) &&
    !$past(lss_id_valid_i) && !$rose(s_axi_bvalid)
    |-> $stable(node_identifier_o))
    else $error("identifier changed without reassignment");
  a_nv_hold: assert property (nv_req_o && !nv_ack_i |=> nv_req_o &&
    $stable(nv_addr_o) && $stable(nv_we_o))
    else $error("store request dropped or changed before answer");
endmodule // aips_top_properties
`default_nettype wire

/* verif/aips_nv_model.sv */
// Behavioural nonvolatile setup store answering the block's access port
`timescale 1ns/1ps
`default_nettype none
module aips_nv_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Access port from the block
  input wire logic nv_req_i,
  input wire logic nv_we_i,
  input wire logic [3:0] nv_addr_i,
  input wire logic [31:0] nv_wdata_i,
  output logic [31:0] nv_rdata_o,
  output logic nv_ack_o,
  // Preset and pacing from the bench
  input wire logic preset_i,
  input wire logic [31:0] tbl_i,
  input wire logic [31:0] ret_i,
  input wire logic [1:0] dly_i
);
  logic [31:0] mem_q [0:15];
  logic [1:0] cnt_q;
  logic hit;
  assign hit = nv_req_i && !nv_ack_o && cnt_q >= dly_i;
  // Contents survive the block's reset, like real storage
  always @(posedge sys_clk_i) begin
    if (preset_i) begin
      for (int k = 0; k < 16; k++) begin
        mem_q[k] <= {4'(k), 28'h5A3C96E};
      end
      mem_q[0] <= tbl_i;
      mem_q[8] <= ret_i;
    end else if (hit && nv_we_i) begin
      mem_q[nv_addr_i] <= nv_wdata_i;
    end
  end
  // Answer after dly_i cycles; data line churns when not answering
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      nv_ack_o <= 1'b0;
      nv_rdata_o <= 32'h0;
    end else if (hit) begin
      cnt_q <= 2'h0;
      nv_ack_o <= 1'b1;
      nv_rdata_o <= mem_q[nv_addr_i];
    end else begin
      cnt_q <= (nv_req_i && !nv_ack_o) ? cnt_q + 2'h1 : 2'h0;
      nv_ack_o <= 1'b0;
      nv_rdata_o <= ~nv_rdata_o;
    end
  end
endmodule // aips_nv_model
`default_nettype wire

/* verif/aips_top_tb.sv */
// Self-checking bench for the node identifier power-on selection block
`timescale 1ns/1ps
`default_nettype none
`include "aips_regs.vh"
module aips_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, lss_v = 1'b0;
  logic rx_v = 1'b0, rx_l = 1'b0, tx_r = 1'b0, tx_l = 1'b0;
  logic preset = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic nv_req, nv_we, nv_ack, rx_acc, tx_all, unconf, rdy, boot;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lss_id = 8'h00, nid;
  logic [31:0] wdata = 32'h0, tbl = 32'h0, ret = 32'h0, rdata, sdata;
  logic [31:0] nv_wdata, nv_rdata;
  logic [3:0] wstrb = 4'h0, sw = 4'h0, nv_addr;
  logic [2:0] sidx = 3'h0, pidx = 3'h0;
  logic [1:0] dly = 2'h0, bresp, rresp, r2;
  logic [31:0] d;
  int fails = 0, n_compared = 0, boots = 0, cyc = 0;
  aips_top uut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .nv_req_o(nv_req), .nv_we_o(nv_we),
    .nv_addr_o(nv_addr), .nv_wdata_o(nv_wdata), .nv_rdata_i(nv_rdata),
    .nv_ack_i(nv_ack), .node_id_rotary_switch_i(sw),
    .lss_id_valid_i(lss_v), .lss_id_i(lss_id), .rx_cmd_valid_i(rx_v),
    .rx_cmd_is_lss_i(rx_l), .rx_accept_o(rx_acc), .tx_req_i(tx_r),
    .tx_is_lss_i(tx_l), .tx_allow_o(tx_all), .node_identifier_o(nid),
    .unconfigured_o(unconf), .id_ready_o(rdy), .boot_up_o(boot),
    .setup_idx_i(sidx), .setup_data_o(sdata));
  aips_nv_model nv (.sys_clk_i(clk), .rst_n_i(rst_n), .nv_req_i(nv_req),
    .nv_we_i(nv_we), .nv_addr_i(nv_addr), .nv_wdata_i(nv_wdata),
    .nv_rdata_o(nv_rdata), .nv_ack_o(nv_ack), .preset_i(preset),
    .tbl_i(tbl), .ret_i(ret), .dly_i(dly));
  // ---------------------------------------------------------------
  // Clock, watchdog, random filter traffic, RAM copy monitor
  // ---------------------------------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  // Words 1..7 only: word 0 may be rewritten by later assignments
  always @(posedge clk) begin
    if (boot === 1'b1) boots++;
    if (rdy === 1'b1 && pidx != 3'h0) chk(sdata, nv.mem_q[pidx]);
    pidx <= sidx;
    {rx_v, rx_l, tx_r, tx_l, sidx} <= 7'($urandom);
  end
  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s, output logic [1:0] r);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Returns {unconfigured, identifier} as selected in CANopen mode
  function automatic logic [8:0] exp_sel(input logic [31:0] t,
      input logic [31:0] r, input logic [3:0] s);
    logic [7:0] v;
    v = 8'h00;
    if (t[31:16] == `AIPS_SIG && t[8]) v = t[7:0];
    else if (r[8]) v = r[7:0];
    if (v == 8'h00) v = {4'h0, s};
    if (v == 8'h00 || v > `AIPS_ID_CO_MAX) return {1'b1, `AIPS_ID_UNCONF};
    return {1'b0, v};
  endfunction
  // Power cycle; fresh rewrites the store, else contents are kept
  task automatic power_on(input logic [31:0] t, input logic [31:0] r,
      input logic [3:0] s, input logic fresh);
    logic [8:0] e;
    preset <= fresh;
    tbl <= t;
    ret <= r;
    sw <= s;
    rst_n <= 1'b0;
    dly <= 2'($urandom);
    repeat (8) @(posedge clk);
    e = exp_sel(nv.mem_q[0], nv.mem_q[8], s);
    boots = 0;
    preset <= 1'b0;
    rst_n <= 1'b1;
    while (rdy !== 1'b1) @(posedge clk);
    @(posedge clk);
    chk(32'({unconf, nid}), 32'(e));
    chk(boots, 32'(!e[8]));
    axi_rd(`AIPS_STAT, d, r2);
    chk(32'(d[9:0]), {22'h0, 1'b1, e});
  endtask
  task automatic wait_ret(input logic [8:0] v);
    for (int n = 0; n < 60 && nv.mem_q[8][8:0] !== v; n++) @(posedge clk);
    chk(32'(nv.mem_q[8][8:0]), 32'(v));
  endtask
  task automatic end_of_test();
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hAA65));
    power_on(32'hA5C3017F, 32'h0, 4'h3, 1'b1);
    power_on(32'hA5C30100, 32'h0, 4'h9, 1'b1);
    power_on(32'hA5C30022, 32'h133, 4'h1, 1'b1);
    power_on(32'h12340144, 32'h144, 4'h2, 1'b1);
    power_on(32'h0, 32'h0, 4'hC, 1'b1);
    for (int i = 0; i < 8; i++) begin
      power_on({i[0] ? `AIPS_SIG : 16'($urandom), 7'h0, 1'($urandom),
        8'($urandom)}, {23'h0, 1'($urandom), 8'($urandom_range(127))},
        4'($urandom), 1'b1);
    end
    power_on(32'hA5C30180, 32'h0, 4'h5, 1'b1);
    axi_wr(`AIPS_ASGN, 32'h0, 4'hF, r2);
    chk(32'(r2), 32'(`AIPS_SLVERR));
    axi_wr(`AIPS_ASGN, 32'h33, 4'hE, r2);
    chk(32'({r2, unconf}), 32'h5);
    axi_wr(`AIPS_ASGN, 32'hC8, 4'hF, r2);
    chk(32'({unconf, nid}), 32'h1FF);
    boots = 0;
    axi_wr(`AIPS_ASGN, 32'h55, 4'hF, r2);
    repeat (2) @(posedge clk);
    chk(32'({unconf, nid, boots[0]}), 32'h0AB);
    wait_ret(9'h155);
    power_on(32'h0, 32'h0, 4'h7, 1'b0);
    lss_id <= 8'h12;
    lss_v <= 1'b1;
    @(posedge clk);
    lss_v <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({unconf, nid}), 32'h012);
    wait_ret(9'h112);
    power_on(32'h0, 32'h0, 4'h4, 1'b0);
    lss_id <= 8'h90;
    lss_v <= 1'b1;
    @(posedge clk);
    lss_v <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({unconf, nid}), 32'h1FF);
    axi_rd(8'h40, d, r2);
    chk({d[29:0], r2}, 32'(`AIPS_SLVERR));
    // Outside CANopen an identifier above 127 is kept and configures
    axi_wr(`AIPS_CTRL, 32'h0, 4'hF, r2);
    axi_wr(`AIPS_ASGN, 32'hC8, 4'hF, r2);
    chk(32'({r2, unconf, nid}), 32'h0C8);
    end_of_test();
  end
endmodule // aips_top_tb
bind aips_top aips_top_properties chk_u (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .s_axi_bvalid(s_axi_bvalid),
  .lss_id_valid_i(lss_id_valid_i), .nv_req_o(nv_req_o), .nv_we_o(nv_we_o),
  .nv_addr_o(nv_addr_o), .nv_ack_i(nv_ack_i),
  .rx_cmd_valid_i(rx_cmd_valid_i), .rx_cmd_is_lss_i(rx_cmd_is_lss_i),
  .rx_accept_o(rx_accept_o), .tx_req_i(tx_req_i), .tx_is_lss_i(tx_is_lss_i),
  .tx_allow_o(tx_allow_o), .node_identifier_o(node_identifier_o),
  .unconfigured_o(unconfigured_o), .id_ready_o(id_ready_o),
  .boot_up_o(boot_up_o));
`default_nettype wire
